// [hdl/psw_map.vh]
`ifndef PSW_MAP_VH
`define PSW_MAP_VH
//****************************************************************
// Overview of operation
//****************************************************************
// Overview of operation
// - switch off only for high-voltage 1, enable 0
// - either enable toggling clears latched faults
// - startup boost limit multiple during boost time
// - foldback temperature forces power limiting mode
// - uncharged output at startup timeout latches off
// - relaxed reverse threshold for 16 ms after startup ends
// - input debounce before turn-on above lockout
// - input lost during debounce abandons turn-on
// - output already up skips debounce delay
// - overvoltage select picks preset or adjusted threshold
// - undervoltage select picks preset or adjusted threshold
// - continuous at power-up, sample selects after timeout
// - select decode 00 latch, 01 retry, else continuous
// - severe overload: FETs off, restart after 420 us
// - latchoff: severe overload beyond blanking latches off
// - autoretry blanking timer starts, resets, then trips
// - retry off time then on again, flag held
// - latchoff: blanking expiry holds off until toggle
// - flag follows drop threshold, released in continuous
// - reverse current turns FETs off for recovery time
// - recovery then 420 us or 1.5 ms, restart
// - reverse events always restart in every mode
// - flag on reverse, heat, grounded set, lockouts
// - heat: retry off time in autoretry, latch in latchoff

// times in microseconds, clock in MHz
`define CLK_MHZ        100
`define T_BOOST_US     24000
`define T_TIMEOUT_US   1090000
`define T_REVWIN_US    16000
`define T_DEBOUNCE_US  1500
`define T_RESTART_US   420
`define T_BLANK_US     24000
`define T_RETRY_US     720000
`define T_REVREC_US    2400
`define T_BOOST_CYC    (`T_BOOST_US * `CLK_MHZ)
`define T_TIMEOUT_CYC  (`T_TIMEOUT_US * `CLK_MHZ)
`define T_REVWIN_CYC   (`T_REVWIN_US * `CLK_MHZ)
`define T_DEBOUNCE_CYC (`T_DEBOUNCE_US * `CLK_MHZ)
`define T_RESTART_CYC  (`T_RESTART_US * `CLK_MHZ)
`define T_BLANK_CYC    (`T_BLANK_US * `CLK_MHZ)
`define T_RETRY_CYC    (`T_RETRY_US * `CLK_MHZ)
`define T_REVREC_CYC   (`T_REVREC_US * `CLK_MHZ)

// limit type decode {hi,lo}
`define LT_LATCH       2'h0
`define LT_RETRY       2'h1
// boost multiple codes
`define BOOST_1X       2'h0
`define BOOST_1P5X     2'h1
`define BOOST_2X       2'h2
`endif

// [hdl/psw_sync.v]
// three-stage synchroniser; a change is taken once stages two and three agree
module psw_sync #(
	parameter W = 1
) (
	input  wire         i_clk,
	input  wire         i_reset,
	input  wire [W-1:0] i_async,
	output reg  [W-1:0] o_sync
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;

	// first stage feeds only the second
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s1_r   <= {W{1'b0}};
			s2_r   <= {W{1'b0}};
			s3_r   <= {W{1'b0}};
			o_sync <= {W{1'b0}};
		end else begin
			s1_r <= i_async;
			s2_r <= s1_r;
			s3_r <= s2_r;
			o_sync <= (s2_r & s3_r) | (o_sync & (s2_r | s3_r));
		end
	end
endmodule

// [hdl/psw_timer.v]
// one-shot down counter: load starts it, done pulses at expiry
module psw_timer #(
	parameter W = 32
) (
	input  wire         i_clk,
	input  wire         i_reset,
	input  wire         i_load,
	input  wire         i_stop,
	input  wire [W-1:0] i_count,
	output wire         o_busy,
	output reg          o_done
);
	reg [W-1:0] cnt_r;

	assign o_busy = (cnt_r != {W{1'b0}});

	// load wins over stop so a restart in the stopping cycle holds
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_r  <= {W{1'b0}};
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_load) begin
				cnt_r <= i_count;
			end else if (i_stop) begin
				cnt_r <= {W{1'b0}};
			end else if (o_busy) begin
				cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
				if (cnt_r == {{(W-1){1'b0}}, 1'b1})
					o_done <= 1'b1;
			end
		end
	end
endmodule

// [hdl/power_switch_fault_controller.v]
`include "psw_map.vh"

module power_switch_fault_controller #(
	parameter [31:0] BOOST_CYC    = `T_BOOST_CYC,
	parameter [31:0] TIMEOUT_CYC  = `T_TIMEOUT_CYC,
	parameter [31:0] REVWIN_CYC   = `T_REVWIN_CYC,
	parameter [31:0] DEBOUNCE_CYC = `T_DEBOUNCE_CYC,
	parameter [31:0] RESTART_CYC  = `T_RESTART_CYC,
	parameter [31:0] BLANK_CYC    = `T_BLANK_CYC,
	parameter [31:0] RETRY_CYC    = `T_RETRY_CYC,
	parameter [31:0] REVREC_CYC   = `T_REVREC_CYC,
	parameter [1:0]  BOOST_MULT   = `BOOST_1X
) (
	// clock and power-on reset
	input  wire       i_clk,
	input  wire       i_reset,
	// enables and straps
	input  wire       i_hv_enable_low,
	input  wire       i_enable,
	input  wire       i_limit_type_sel_lo,
	input  wire       i_limit_type_sel_hi,
	input  wire       i_reverse_block_enable,
	// analog comparators
	input  wire       i_in_above_undervoltage_lockout,
	input  wire       i_in_at_overvoltage_lockout,
	input  wire       i_out_above_undervoltage_lockout,
	input  wire       i_output_charged,
	input  wire       i_at_limit,
	input  wire       i_over_2x,
	input  wire       i_drop_high,
	input  wire       i_reverse,
	input  wire       i_foldback,
	input  wire       i_overtemp,
	input  wire       i_set_grounded,
	input  wire       i_overvoltage_lockout_sel_above,
	input  wire       i_undervoltage_lockout_sel_above,
	// gate and analog control
	output reg        o_fet_on,
	output reg  [1:0] o_limit_mult,
	output reg        o_power_limit,
	output reg        o_rev_relaxed,
	output reg        o_overvoltage_lockout_adjusted,
	output reg        o_undervoltage_lockout_adjusted,
	output reg  [1:0] o_limit_type,
	output reg        o_fault_indicator_n,
	output reg        o_fault_indicator_oe
);
	//************************************************************
	// input synchronisation
	//************************************************************
	wire [17:0] raw = {i_hv_enable_low, i_enable, i_limit_type_sel_lo,
		i_limit_type_sel_hi, i_reverse_block_enable, i_in_above_undervoltage_lockout,
		i_in_at_overvoltage_lockout, i_out_above_undervoltage_lockout, i_output_charged, i_at_limit,
		i_over_2x, i_drop_high, i_reverse, i_foldback, i_overtemp,
		i_set_grounded, i_overvoltage_lockout_sel_above, i_undervoltage_lockout_sel_above};
	wire [17:0] s;
	psw_sync #(.W(18)) u_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_async (raw),
		.o_sync  (s)
	);
	wire hv_n   = s[17];
	wire en     = s[16];
	wire sel_lo = s[15];
	wire sel_hi = s[14];
	wire rev_en = s[13];
	wire in_ok  = s[12];
	wire overvoltage_lockout   = s[11];
	wire out_ok = s[10];
	wire chgd   = s[9];
	wire at_lim = s[8];
	wire over2  = s[7];
	wire drop   = s[6];
	wire rev    = s[5];
	wire fold   = s[4];
	wire otemp  = s[3];
	wire setgnd = s[2];

	//************************************************************
	// enable decode and fault clear
	//************************************************************
	reg  hv_d_r;
	reg  en_d_r;
	wire enabled = ~(hv_n & ~en);
	wire toggle  = (hv_n ^ hv_d_r) | (en ^ en_d_r);
	wire power_ok = in_ok & ~overvoltage_lockout & ~setgnd;

	// previous enable levels for edge detection
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			hv_d_r <= 1'b0;                               // sync resets low too
			en_d_r <= 1'b0;
		end else begin
			hv_d_r <= hv_n;
			en_d_r <= en;
		end
	end

	//************************************************************
	// timers
	//************************************************************
	localparam S_OFF     = 3'h0;
	localparam S_DEB     = 3'h1;
	localparam S_START   = 3'h2;
	localparam S_RUN     = 3'h3;
	localparam S_RETRY   = 3'h4;
	localparam S_LATCH   = 3'h5;
	localparam S_REVREC  = 3'h6;
	localparam S_RESTART = 3'h7;

	reg  [2:0]  state_r;
	reg  [2:0]  state_nxt;
	reg         ld_a;
	reg  [31:0] cnt_a;
	reg         ld_b;
	wire        busy_a;
	wire        done_a;
	wire        busy_b;
	wire        done_b;
	wire        busy_w;
	wire        done_w;
	wire        busy_r;
	// declared ahead of the timers that use them
	wire        ld_boost = (state_r != S_START) && (state_nxt == S_START);
	wire        ld_rw    = (state_r == S_START) && (state_nxt == S_RUN);

	// sequence timer: debounce, timeout, retry, recovery, restart
	psw_timer #(.W(32)) u_seq (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_load  (ld_a),
		.i_stop  (1'b0),
		.i_count (cnt_a),
		.o_busy  (busy_a),
		.o_done  (done_a)
	);
	// blanking timer, cleared while current sits below the limit
	psw_timer #(.W(32)) u_blank (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_load  (ld_b),
		.i_stop  (~at_lim & ~over2),
		.i_count (BLANK_CYC),
		.o_busy  (busy_b),
		.o_done  (done_b)
	);
	// boost window, started with each startup
	psw_timer #(.W(32)) u_boost (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_load  (ld_boost),
		.i_stop  (1'b0),
		.i_count (BOOST_CYC),
		.o_busy  (busy_w),
		.o_done  ()
	);
	// relaxed reverse window at the end of startup
	psw_timer #(.W(32)) u_revwin (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_load  (ld_rw),
		.i_stop  (1'b0),
		.i_count (REVWIN_CYC),
		.o_busy  (busy_r),
		.o_done  (done_w)
	);

	//************************************************************
	// limit type capture
	//************************************************************
	reg [1:0] type_r;
	reg       otemp_trip_r;
	wire lt_latch = (type_r == `LT_LATCH);
	wire lt_retry = (type_r == `LT_RETRY);

	// continuous at power-up; selects sampled once startup timeout ends
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			type_r <= 2'h2;
		end else if (state_r == S_START && done_a && chgd) begin
			type_r <= {sel_hi, sel_lo};
		end
	end

	//************************************************************
	// main sequencer
	//************************************************************
	always @* begin
		state_nxt = state_r;
		ld_a      = 1'b0;
		cnt_a     = 32'h0;
		ld_b      = 1'b0;
		case (state_r)
		S_OFF: begin
			if (enabled && power_ok && !otemp) begin
				if (out_ok) begin
					state_nxt = S_START;
					ld_a      = 1'b1;
					cnt_a     = TIMEOUT_CYC;
				end else begin
					state_nxt = S_DEB;
					ld_a      = 1'b1;
					cnt_a     = DEBOUNCE_CYC;
				end
			end
		end
		S_DEB: begin
			if (!enabled || !power_ok) begin
				state_nxt = S_OFF;
			end else if (done_a) begin
				state_nxt = S_START;
				ld_a      = 1'b1;
				cnt_a     = TIMEOUT_CYC;
			end
		end
		S_START: begin
			if (done_a && !chgd) begin
				state_nxt = S_LATCH;
			end else if (done_a) begin
				state_nxt = S_RUN;
			end
		end
		S_RUN: begin
			if ((at_lim || over2) && !busy_b)
				ld_b = 1'b1;
			if (over2 && lt_latch && done_b) begin
				state_nxt = S_LATCH;
			end else if (over2) begin
				state_nxt = S_RESTART;
				ld_a      = 1'b1;
				cnt_a     = RESTART_CYC;
			end else if (done_b && lt_latch) begin
				state_nxt = S_LATCH;
			end else if (done_b && lt_retry) begin
				state_nxt = S_RETRY;
				ld_a      = 1'b1;
				cnt_a     = RETRY_CYC;
			end
		end
		S_RETRY: begin
			if (otemp) begin
				ld_a  = 1'b1;
				cnt_a = RETRY_CYC;
			end else if (done_a) begin
				state_nxt = S_START;
				ld_a      = 1'b1;
				cnt_a     = TIMEOUT_CYC;
			end
		end
		S_REVREC: begin
			if (!busy_a && !rev) begin
				state_nxt = S_RESTART;
				ld_a      = 1'b1;
				cnt_a     = out_ok ? RESTART_CYC : DEBOUNCE_CYC;
			end
		end
		S_RESTART: begin
			if (done_a) begin
				state_nxt = S_START;
				ld_a      = 1'b1;
				cnt_a     = TIMEOUT_CYC;
			end
		end
		S_LATCH: begin
			state_nxt = S_LATCH;
		end
		default: begin
			state_nxt = S_OFF;
		end
		endcase
		// overtemperature: retry timing, latch, or wait for cooling
		if (otemp && state_r != S_LATCH && state_r != S_RETRY &&
			state_r != S_OFF) begin
			if (lt_latch) begin
				state_nxt = S_LATCH;
			end else if (lt_retry) begin
				state_nxt = S_RETRY;
				ld_a      = 1'b1;
				cnt_a     = RETRY_CYC;
			end else begin
				state_nxt = S_OFF;
			end
		end
		// latchoff: severe overload outlasting blanking across restarts
		if (lt_latch && over2 && done_b && (state_r == S_RESTART ||
			state_r == S_START)) begin
			state_nxt = S_LATCH;
			ld_a      = 1'b0;
		end
		// reverse current restarts in every mode
		if (rev_en && rev && !busy_r && (state_r == S_RUN ||
			state_r == S_START) && !otemp) begin
			state_nxt = S_REVREC;
			ld_a      = 1'b1;
			cnt_a     = REVREC_CYC;
		end
		// toggling an enable or losing power clears every latch
		if (toggle || !enabled || !power_ok) begin
			state_nxt = S_OFF;
			ld_a      = 1'b0;
		end
	end

	// state register
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			state_r <= S_OFF;
		else
			state_r <= state_nxt;
	end

	//************************************************************
	// outputs
	//************************************************************
	wire fet_nxt  = (state_nxt == S_START) || (state_nxt == S_RUN);
	wire flag_act = (drop & fet_nxt) | (state_r == S_REVREC) | otemp |
		setgnd | ~in_ok | overvoltage_lockout |
		((state_nxt == S_RETRY) & lt_retry);

	// all outputs registered; flag is open drain, low while asserted
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_fet_on             <= 1'b0;
			o_limit_mult         <= `BOOST_1X;
			o_power_limit        <= 1'b0;
			o_rev_relaxed        <= 1'b0;
			o_overvoltage_lockout_adjusted      <= 1'b0;
			o_undervoltage_lockout_adjusted      <= 1'b0;
			o_limit_type         <= 2'h2;
			o_fault_indicator_n  <= 1'b1;
			o_fault_indicator_oe <= 1'b0;
		end else begin
			o_fet_on        <= fet_nxt;
			// boost from the first cycle the gate is on
			o_limit_mult    <= (state_nxt == S_START &&
				(busy_w || ld_boost)) ? BOOST_MULT : `BOOST_1X;
			o_power_limit   <= fold;
			o_rev_relaxed   <= busy_r;
			o_overvoltage_lockout_adjusted <= s[1];
			o_undervoltage_lockout_adjusted <= s[0];
			o_limit_type    <= type_r;
			o_fault_indicator_n  <= ~flag_act;
			o_fault_indicator_oe <= flag_act;
		end
	end
endmodule

// [tb/psw_fault_sva.sv]
module psw_fault_sva (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// inputs watched
	input wire logic i_hv_enable_low,
	input wire logic i_enable,
	input wire logic i_over_2x,
	input wire logic i_reverse,
	input wire logic i_reverse_block_enable,
	input wire logic i_foldback,
	input wire logic i_set_grounded,
	input wire logic i_overvoltage_lockout_sel_above,
	input wire logic i_undervoltage_lockout_sel_above,
	// outputs watched
	input wire logic o_fet_on,
	input wire logic o_power_limit,
	input wire logic o_rev_relaxed,
	input wire logic o_overvoltage_lockout_adjusted,
	input wire logic o_undervoltage_lockout_adjusted,
	input wire logic o_fault_indicator_n,
	input wire logic o_fault_indicator_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	// one domain, so one clocking and reset for all checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	//****************************************************************
	// checks; windows of 8 cover the synchroniser latency
	//****************************************************************
	a_flag_drive_oe: assert property (
		o_fault_indicator_oe == !o_fault_indicator_n)
		else $error("flag enable does not match flag level");
	a_foldback_limit: assert property (
		i_foldback [*8] |-> o_power_limit)
		else $error("foldback did not force power limiting");
	a_enable_off: assert property (
		(i_hv_enable_low && !i_enable) [*8] |-> !o_fet_on)
		else $error("switch on with enables in off state");
	a_overvoltage_lockout_select: assert property (
		$stable(i_overvoltage_lockout_sel_above) [*8] |->
		o_overvoltage_lockout_adjusted == i_overvoltage_lockout_sel_above)
		else $error("overvoltage threshold select wrong");
	a_undervoltage_lockout_select: assert property (
		$stable(i_undervoltage_lockout_sel_above) [*8] |->
		o_undervoltage_lockout_adjusted == i_undervoltage_lockout_sel_above)
		else $error("undervoltage threshold select wrong");
	a_severe_off: assert property (
		$rose(i_over_2x) |-> ##[1:8] !o_fet_on)
		else $error("severe overload did not turn the switch off");
	a_reverse_off: assert property (
		$rose(i_reverse) && i_reverse_block_enable && !o_rev_relaxed
		|-> ##[1:8] !o_fet_on)
		else $error("reverse current did not turn the switch off");
	a_set_gnd_flag: assert property (
		i_set_grounded [*8] |-> !o_fault_indicator_n)
		else $error("grounded set pin not flagged");
	a_edge_clear: assert property (
		$changed(i_enable) |-> ##[1:8] !o_fet_on)
		else $error("enable edge did not pass through off");
endmodule

bind power_switch_fault_controller psw_fault_sva sva_u (.i_clk, .i_reset,
	.i_hv_enable_low, .i_enable, .i_over_2x, .i_reverse,
	.i_reverse_block_enable, .i_foldback, .i_set_grounded,
	.i_overvoltage_lockout_sel_above, .i_undervoltage_lockout_sel_above, .o_fet_on, .o_power_limit,
	.o_rev_relaxed, .o_overvoltage_lockout_adjusted, .o_undervoltage_lockout_adjusted,
	.o_fault_indicator_n, .o_fault_indicator_oe);

// [tb/psw_far_side.sv]
module psw_far_side (
	// clock and fet gate
	input  wire logic i_clk,
	input  wire logic i_fet_on,
	// load conditions from the bench
	input  wire logic i_short,
	input  wire logic i_heavy,
	input  wire logic i_keep,
	// comparator levels back to the block
	output wire logic o_output_charged,
	output wire logic o_out_above_undervoltage_lockout,
	output wire logic o_at_limit,
	output wire logic o_drop_high
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] chg_r = 4'h0;
	//****************************************************************
	// output capacitor
	//****************************************************************
	// charges in 10 cycles unless the load is too heavy; gate off drains
	always @(posedge i_clk) begin
		if (!i_fet_on || i_heavy)
			chg_r <= 4'h0;
		else if (chg_r != 4'ha)
			chg_r <= chg_r + 4'h1;
	end
	assign o_output_charged = (chg_r == 4'ha);
	// keep models a supply already holding the output up
	assign o_out_above_undervoltage_lockout = o_output_charged | i_keep;
	// limiting while charging or shorted; the drop follows the limit
	assign o_at_limit = i_fet_on & (i_short | !o_output_charged);
	assign o_drop_high = o_at_limit;
endmodule

// [tb/power_switch_fault_controller_tb_top.sv]
module power_switch_fault_controller_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, hv, en, s_lo, s_hi, in_ok, shrt, heavy, keep;
	logic x2, rev, rev_en, fold, sgnd, ovs, uvs, ovl, otmp;
	wire logic chgd, out_ok, at_lim, drop;
	wire logic fet, pl, rr, ova, uva, flag_n, oe;
	wire logic [1:0] mult, ltype;
	int miscompares = 0;
	int n_tests = 0;
	//****************************************************************
	// clock, design and far side
	//****************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// short counts keep each timer to 200 cycles or fewer
	localparam int         BOOST_CYC    = 20;
	localparam int         TIMEOUT_CYC  = 200;
	localparam int         REVWIN_CYC   = 30;
	localparam int         DEBOUNCE_CYC = 50;
	localparam int         RESTART_CYC  = 20;
	localparam int         BLANK_CYC    = 40;
	localparam int         RETRY_CYC    = 100;
	localparam int         REVREC_CYC   = 30;
	localparam logic [1:0] BOOST_MULT   = 2'h2;
	power_switch_fault_controller #(.BOOST_CYC(BOOST_CYC),
		.TIMEOUT_CYC(TIMEOUT_CYC), .REVWIN_CYC(REVWIN_CYC),
		.DEBOUNCE_CYC(DEBOUNCE_CYC), .RESTART_CYC(RESTART_CYC),
		.BLANK_CYC(BLANK_CYC), .RETRY_CYC(RETRY_CYC),
		.REVREC_CYC(REVREC_CYC), .BOOST_MULT(BOOST_MULT)) dut_u (
		.i_clk(clk), .i_reset(rst),
		.i_hv_enable_low(hv), .i_enable(en), .i_limit_type_sel_lo(s_lo),
		.i_limit_type_sel_hi(s_hi), .i_reverse_block_enable(rev_en),
		.i_in_above_undervoltage_lockout(in_ok), .i_in_at_overvoltage_lockout(ovl),
		.i_out_above_undervoltage_lockout(out_ok), .i_output_charged(chgd),
		.i_at_limit(at_lim), .i_over_2x(x2), .i_drop_high(drop),
		.i_reverse(rev), .i_foldback(fold), .i_overtemp(otmp),
		.i_set_grounded(sgnd), .i_overvoltage_lockout_sel_above(ovs),
		.i_undervoltage_lockout_sel_above(uvs), .o_fet_on(fet), .o_limit_mult(mult),
		.o_power_limit(pl), .o_rev_relaxed(rr), .o_overvoltage_lockout_adjusted(ova),
		.o_undervoltage_lockout_adjusted(uva), .o_limit_type(ltype),
		.o_fault_indicator_n(flag_n), .o_fault_indicator_oe(oe));
	psw_far_side far_u (.i_clk(clk), .i_fet_on(fet), .i_short(shrt),
		.i_heavy(heavy), .i_keep(keep), .o_output_charged(chgd),
		.o_out_above_undervoltage_lockout(out_ok), .o_at_limit(at_lim),
		.o_drop_high(drop));
	//****************************************************************
	// shared tasks
	//****************************************************************
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [1:0] got,
		input logic [1:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// bounded wait for the gate to reach a level
	task automatic wait_fet(input logic lvl, input int bound);
		int i;
		for (i = 0; i < bound && fet !== lvl; i++)
			cyc(1);
		chk("fet wait", {1'b0, fet}, {1'b0, lvl});
		if (fet !== lvl)
			close_out();
	endtask
	// toggling the enable also clears any latch
	task automatic restart;
		hv = 1'b1;
		en = 1'b0;
		cyc(20);
		en = 1'b1;
		wait_fet(1'b1, 400);
	endtask
	//****************************************************************
	// scenarios
	//****************************************************************
	task automatic t_startup;
		in_ok = 1'b1;
		en = 1'b1;
		cyc(30);
		chk("debounce", {1'b0, fet}, 2'h0);
		wait_fet(1'b1, 200);
		cyc(5);
		chk("boost mult", mult, BOOST_MULT);
		cyc(35);
		chk("mult after", mult, 2'h0);
		chk("type early", ltype, 2'h2);
		cyc(175);
		chk("relaxed", {1'b0, rr}, 2'h1);
		cyc(45);
		chk("strict", {1'b0, rr}, 2'h0);
		chk("type late", ltype, 2'h3);
		$display("test startup done");
	endtask
	task automatic t_enables;
		int i;
		for (i = 0; i < 4; i++) begin
			hv = 1'b1;
			en = 1'b0;
			cyc(20);
			{hv, en} = i[1:0];
			cyc(120);
			chk("enable table", {1'b0, fet}, {1'b0, i != 2});
		end
		en = 1'b0;
		cyc(5);
		in_ok = 1'b0;
		cyc(20);
		en = 1'b1;
		cyc(20);
		chk("low input", {1'b0, fet}, 2'h0);
		en = 1'b0;
		cyc(20);
		en = 1'b1;
		in_ok = 1'b1;
		cyc(20);
		in_ok = 1'b0;
		cyc(80);
		chk("abandon", {1'b0, fet}, 2'h0);
		in_ok = 1'b1;
		wait_fet(1'b1, 300);
		keep = 1'b1;
		hv = 1'b1;
		en = 1'b0;
		cyc(20);
		en = 1'b1;
		cyc(15);
		chk("no debounce", {1'b0, fet}, 2'h1);
		keep = 1'b0;
		$display("test enables done");
	endtask
	task automatic t_timeout;
		heavy = 1'b1;
		en = 1'b0;
		cyc(20);
		en = 1'b1;
		cyc(300);
		chk("timeout off", {1'b0, fet}, 2'h0);
		cyc(100);
		chk("stays off", {1'b0, fet}, 2'h0);
		heavy = 1'b0;
		restart();
		$display("test timeout done");
	endtask
	task automatic t_modes;
		{s_hi, s_lo} = 2'h1;
		restart();
		cyc(260);
		chk("type retry", ltype, 2'h1);
		shrt = 1'b1;
		cyc(25);
		shrt = 1'b0;
		cyc(10);
		shrt = 1'b1;
		cyc(25);
		chk("blank reset", {1'b0, fet}, 2'h1);
		wait_fet(1'b0, 100);
		chk("retry flag", {1'b0, flag_n}, 2'h0);
		cyc(50);
		chk("retry off", {1'b0, fet}, 2'h0);
		wait_fet(1'b1, 120);
		shrt = 1'b0;
		{s_hi, s_lo} = 2'h0;
		restart();
		cyc(260);
		chk("type latch", ltype, 2'h0);
		shrt = 1'b1;
		wait_fet(1'b0, 100);
		shrt = 1'b0;
		cyc(200);
		chk("latched", {1'b0, fet}, 2'h0);
		// severe overload held past blanking, through the restart
		restart();
		cyc(260);
		x2 = 1'b1;
		cyc(60);
		x2 = 1'b0;
		cyc(20);
		chk("severe latch", {1'b0, fet}, 2'h0);
		{s_hi, s_lo} = 2'h3;
		restart();
		cyc(260);
		shrt = 1'b1;
		cyc(100);
		chk("continuous", {1'b0, fet}, 2'h1);
		chk("drop flag", {1'b0, flag_n}, 2'h0);
		shrt = 1'b0;
		cyc(15);
		chk("flag gone", {1'b0, flag_n}, 2'h1);
		$display("test modes done");
	endtask
	task automatic t_misc;
		ovs = 1'b1;
		uvs = 1'b1;
		fold = 1'b1;
		cyc(10);
		chk("thresholds", {ova, uva}, 2'h3);
		chk("power limit", {1'b0, pl}, 2'h1);
		{ovs, uvs, fold} = 3'h0;
		x2 = 1'b1;
		cyc(10);
		chk("severe off", {1'b0, fet}, 2'h0);
		chk("thr preset", {ova, uva}, 2'h0);
		x2 = 1'b0;
		wait_fet(1'b1, 400);
		rev_en = 1'b1;
		cyc(260);
		rev = 1'b1;
		cyc(10);
		chk("reverse off", {1'b0, fet}, 2'h0);
		cyc(20);
		rev = 1'b0;
		wait_fet(1'b1, 400);
		sgnd = 1'b1;
		cyc(10);
		chk("set grounded", {1'b0, flag_n}, 2'h0);
		sgnd = 1'b0;
		wait_fet(1'b1, 400);
		ovl = 1'b1;
		cyc(10);
		chk("overvoltage_lockout off", {fet, flag_n}, 2'h0);
		ovl = 1'b0;
		wait_fet(1'b1, 400);
		// continuous mode: off while hot, back on once cool
		otmp = 1'b1;
		cyc(10);
		chk("heat off", {fet, flag_n}, 2'h0);
		otmp = 1'b0;
		wait_fet(1'b1, 400);
		$display("test misc done");
	endtask
	//****************************************************************
	// main sequence
	//****************************************************************
	initial begin
		rst = 1'b1;
		{hv, en, in_ok, shrt, heavy, keep} = 6'h20;
		{s_hi, s_lo, x2, rev, rev_en, fold, sgnd, ovs, uvs} = 9'h180;
		{ovl, otmp} = 2'h0;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		cyc(5);
		t_startup();
		t_enables();
		t_timeout();
		t_modes();
		t_misc();
		close_out();
	end
endmodule
